// >>> design/io_port_pkg.sv
/*
 Constants and register map of the two-bank general-purpose I/O port.
 Assumes a 100 MHz system clock and word-indexed register slots.
*/
// Function
// - Activation bit 0 enables bank three, bit 1 bank four; resets 03h.
// - Direction bit 0 makes the pin an output, 1 an input; resets FFh.
// - Bank three at indexes E0h-E3h, bank four at E4h-E7h, same layout.
// - Output data bits are writable to drive the pin and read back.
// - Input data bits read the pin state; writes to them are ignored.
// - Polarity bit 1 inverts data versus pin, both directions; 0 matches.
// - A rising or falling pin edge sets its flag; flag bit n is pin n.
// - Reading flags returns them and clears the read ones; writes ignored.
// - Data, polarity and flag registers of both banks reset to 00h.
package io_port_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_ACT      = 8'h30;
    localparam logic [7:0] IDX_DIR [2]  = '{8'he0, 8'he4};
    localparam logic [7:0] IDX_VAL [2]  = '{8'he1, 8'he5};
    localparam logic [7:0] IDX_POL [2]  = '{8'he2, 8'he6};
    localparam logic [7:0] IDX_FLG [2]  = '{8'he3, 8'he7};
    localparam logic [7:0] IDX_STAT     = 8'h40;
    localparam logic [7:0] IDX_MASK     = 8'h41;

    // Field positions
    localparam int BIT_BANK_THREE = 0;
    localparam int BIT_BANK_FOUR  = 1;

    // Reset values
    localparam logic [1:0] ACT_RST  = 2'h3;
    localparam logic [7:0] DIR_RST  = 8'hff;
    localparam logic [7:0] VAL_RST  = 8'h00;
    localparam logic [7:0] POL_RST  = 8'h00;
    localparam logic [7:0] FLG_RST  = 8'h00;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

endpackage

// >>> design/io_bank_edge.sv
/*
 One I/O bank's pin synchroniser, edge detector and read-clear flags.
 Assumes pins are asynchronous to mclk_i.
*/
`timescale 1ns/100ps
module io_bank_edge (
    input  wire logic       mclk_i,   // System clock
    input  wire logic       rst_i,    // Async reset, active high
    input  wire logic [7:0] pins_i,   // Raw pin levels
    input  wire logic       active_i, // Bank active
    input  wire logic [7:0] clear_i,  // Flags to clear this cycle
    output logic      [7:0] level_o,  // Synchronised pin levels
    output logic      [7:0] flags_o,  // Edge flags
    output logic      [7:0] edges_o   // Edges recorded this cycle
);

    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] sync;
        logic [7:0] prev;
        logic [7:0] flags;
        logic [2:0] fill;
    } io_bank_state_t;

    io_bank_state_t st_r;
    io_bank_state_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = pins_i;
        st_nxt.sync = st_r.meta;
        st_nxt.prev = st_r.sync;
        // Stages primed first, so a pin idling high fakes no edge
        st_nxt.fill = {st_r.fill[1:0], 1'b1};
        edges_o      = (active_i && st_r.fill[2])
                     ? (st_r.sync ^ st_r.prev) : 8'h00;
        st_nxt.flags = (st_r.flags & ~clear_i) | edges_o;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '{8'h00, 8'h00, 8'h00, io_port_pkg::FLG_RST, 3'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.sync;
    assign flags_o = st_r.flags;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_edge_flag;
        (active_i && st_r.fill[2] && (st_r.sync != st_r.prev))
            |=> ((flags_o & $past(st_r.sync ^ st_r.prev))
                 == $past(st_r.sync ^ st_r.prev));
    endproperty
    a_edge_flag: assert property (p_edge_flag)
        else $error("edge did not set its flag");

    property p_idle_no_flag;
        !active_i |=> ((flags_o & ~$past(flags_o)) == 8'h00);
    endproperty
    a_idle_no_flag: assert property (p_idle_no_flag)
        else $error("flag set while bank inactive");

endmodule // io_bank_edge

// >>> design/dual_bank_io_port.sv
/*
 Two eight-bit I/O banks with direction, data, polarity and read-clear
 edge flags, an activation register and an edge interrupt, reached over
 an Avalon-MM slave with waitrequest. Assumes byte addressing on the bus
 and pins asynchronous to mclk_i.
*/
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
module dual_bank_io_port (
    input  wire logic        mclk_i,              // System clock
    input  wire logic        rst_i,               // Async reset, high
    input  wire logic [9:0]  address_i,           // Byte address
    input  wire logic        read_i,              // Read request
    input  wire logic        write_i,             // Write request
    input  wire logic [31:0] writedata_i,         // Write data
    input  wire logic [3:0]  byteenable_i,        // Byte enables
    output logic      [31:0] readdata_o,          // Read data
    output logic             waitrequest_o,       // Stall request
    input  wire logic [7:0]  bank_three_pins_i,   // Bank three pin in
    output logic      [7:0]  bank_three_pins_o,   // Bank three pin out
    output logic      [7:0]  bank_three_oe_n_o,   // Low drives pin
    input  wire logic [7:0]  bank_four_pins_i,    // Bank four pin in
    output logic      [7:0]  bank_four_pins_o,    // Bank four pin out
    output logic      [7:0]  bank_four_oe_n_o,    // Low drives pin
    output logic             irq_o                // Edge interrupt
);

    typedef struct packed {
        logic [1:0]      act;
        logic [1:0][7:0] dir;
        logic [1:0][7:0] val;
        logic [1:0][7:0] pol;
        logic [1:0][7:0] pout;
        logic [1:0][7:0] oe_n;
        logic [1:0]      stat;
        logic [1:0]      mask;
        logic            rd_done;
        logic [7:0]      rdata;
        logic            irq;
    } port_state_t;

    port_state_t st_r;
    port_state_t st_nxt;

    logic [1:0][7:0] lvl;
    logic [1:0][7:0] flg;
    logic [1:0][7:0] edg;
    logic [1:0][7:0] clr;
    logic [7:0]      idx;
    logic [7:0]      rv;
    logic [7:0]      wd;
    logic            aligned;
    logic            mapped;
    logic            wr;
    logic            rd_ack;

    io_bank_edge u_bank_three (
        .mclk_i   (mclk_i),
        .rst_i    (rst_i),
        .pins_i   (bank_three_pins_i),
        .active_i (st_r.act[io_port_pkg::BIT_BANK_THREE]),
        .clear_i  (clr[0]),
        .level_o  (lvl[0]),
        .flags_o  (flg[0]),
        .edges_o  (edg[0])
    );

    io_bank_edge u_bank_four (
        .mclk_i   (mclk_i),
        .rst_i    (rst_i),
        .pins_i   (bank_four_pins_i),
        .active_i (st_r.act[io_port_pkg::BIT_BANK_FOUR]),
        .clear_i  (clr[1]),
        .level_o  (lvl[1]),
        .flags_o  (flg[1]),
        .edges_o  (edg[1])
    );

    always_comb begin
        st_nxt  = st_r;
        idx     = address_i[9:2];
        aligned = (address_i[1:0] == 2'h0);
        wd      = writedata_i[7:0];
        wr      = write_i & aligned & byteenable_i[0];
        rd_ack  = read_i & st_r.rd_done;
        rv      = 8'h00;
        mapped  = 1'b0;
        clr     = '0;

        // Read decode; unmapped slots read zero
        if (aligned && idx == io_port_pkg::IDX_ACT) begin
            mapped = 1'b1;
            rv     = {6'h00, st_r.act};
        end
        if (aligned && idx == io_port_pkg::IDX_STAT) begin
            mapped = 1'b1;
            rv     = {6'h00, st_r.stat};
        end
        if (aligned && idx == io_port_pkg::IDX_MASK) begin
            mapped = 1'b1;
            rv     = {6'h00, st_r.mask};
        end
        for (int b = 0; b < 2; b++) begin
            if (aligned && idx == io_port_pkg::IDX_DIR[b]) begin
                mapped = 1'b1;
                rv     = st_r.dir[b];
            end
            if (aligned && idx == io_port_pkg::IDX_VAL[b]) begin
                mapped = 1'b1;
                // outputs read back, inputs read pin
                rv = (st_r.val[b] & ~st_r.dir[b])
                   | ((lvl[b] ^ st_r.pol[b]) & st_r.dir[b]);
            end
            if (aligned && idx == io_port_pkg::IDX_POL[b]) begin
                mapped = 1'b1;
                rv     = st_r.pol[b];
            end
            if (aligned && idx == io_port_pkg::IDX_FLG[b]) begin
                mapped = 1'b1;
                rv     = flg[b];
                // clear only bits that were read
                if (rd_ack) begin
                    clr[b] = st_r.rdata;
                end
            end
        end

        // First read cycle latches data, second acknowledges
        if (read_i && !st_r.rd_done) begin
            st_nxt.rdata = rv;
        end
        st_nxt.rd_done = read_i & ~st_r.rd_done;

        // Register writes; flag slots ignore writes
        if (wr && idx == io_port_pkg::IDX_ACT) begin
            st_nxt.act = wd[1:0];
        end
        if (wr && idx == io_port_pkg::IDX_MASK) begin
            st_nxt.mask = wd[1:0];
        end
        for (int b = 0; b < 2; b++) begin
            if (wr && idx == io_port_pkg::IDX_DIR[b]) begin
                st_nxt.dir[b] = wd;
            end
            if (wr && idx == io_port_pkg::IDX_VAL[b]) begin
                // only output bits take the write
                st_nxt.val[b] = (st_r.val[b] & st_r.dir[b])
                              | (wd & ~st_r.dir[b]);
            end
            if (wr && idx == io_port_pkg::IDX_POL[b]) begin
                st_nxt.pol[b] = wd;
            end
        end

        // Edge status: write one clears, new edge wins
        st_nxt.stat = st_r.stat;
        if (wr && idx == io_port_pkg::IDX_STAT) begin
            st_nxt.stat = st_r.stat & ~wd[1:0];
        end
        st_nxt.stat = st_nxt.stat | {(|edg[1]), (|edg[0])};
        st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);

        for (int b = 0; b < 2; b++) begin
            st_nxt.pout[b] = st_nxt.val[b] ^ st_nxt.pol[b];
            // drive only output bits of an active bank
            st_nxt.oe_n[b] = st_nxt.act[b] ? st_nxt.dir[b] : 8'hff;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r.act     <= io_port_pkg::ACT_RST;
            st_r.dir     <= {2{io_port_pkg::DIR_RST}};
            st_r.val     <= {2{io_port_pkg::VAL_RST}};
            st_r.pol     <= {2{io_port_pkg::POL_RST}};
            st_r.pout    <= {2{io_port_pkg::VAL_RST ^ io_port_pkg::POL_RST}};
            st_r.oe_n    <= {2{io_port_pkg::DIR_RST}};
            st_r.stat    <= io_port_pkg::STAT_RST;
            st_r.mask    <= io_port_pkg::MASK_RST;
            st_r.rd_done <= 1'b0;
            st_r.rdata   <= 8'h00;
            st_r.irq     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign readdata_o        = {24'h000000, st_r.rdata};
    assign waitrequest_o     = read_i & ~st_r.rd_done;
    assign bank_three_pins_o = st_r.pout[0];
    assign bank_three_oe_n_o = st_r.oe_n[0];
    assign bank_four_pins_o  = st_r.pout[1];
    assign bank_four_oe_n_o  = st_r.oe_n[1];
    assign irq_o             = st_r.irq;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_idle_undriven;
        !st_r.act[0] |-> (bank_three_oe_n_o == 8'hff);
    endproperty
    a_idle_undriven: assert property (p_idle_undriven)
        else $error("inactive bank three drives a pin");

    property p_dir_drive;
        st_r.act[1] |-> (bank_four_oe_n_o == st_r.dir[1]);
    endproperty
    a_dir_drive: assert property (p_dir_drive)
        else $error("bank four drive differs from direction");

    property p_pol_pin;
        (bank_three_pins_o ^ st_r.pol[0]) == st_r.val[0];
    endproperty
    a_pol_pin: assert property (p_pol_pin)
        else $error("bank three pin ignores polarity");

    property p_wr_out;
        (wr && idx == io_port_pkg::IDX_VAL[0])
            |=> ((st_r.val[0] & ~$past(st_r.dir[0]))
                 == ($past(wd) & ~$past(st_r.dir[0])));
    endproperty
    a_wr_out: assert property (p_wr_out)
        else $error("output data bit not written");

    property p_wr_in;
        (wr && idx == io_port_pkg::IDX_VAL[1])
            |=> ((st_r.val[1] & $past(st_r.dir[1]))
                 == ($past(st_r.val[1]) & $past(st_r.dir[1])));
    endproperty
    a_wr_in: assert property (p_wr_in)
        else $error("input data bit took a write");

    property p_read_clear;
        (rd_ack && aligned && idx == io_port_pkg::IDX_FLG[0])
            |=> ((flg[0] & $past(st_r.rdata) & ~$past(edg[0])) == 8'h00);
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("read flag bit not cleared");

    property p_unmapped;
        (read_i && !waitrequest_o && !mapped) |-> (readdata_o == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned data");

    property p_irq_level;
        irq_o == |(st_r.stat & st_r.mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level wrong");

endmodule // dual_bank_io_port

// >>> tb/io_board_model.sv
/*
 Board side of one eight-bit I/O bank: resolves each pin from the
 port's output enable and the board's own drivers.
 Assumes the board drives every pin that the port leaves undriven.
*/
`timescale 1ns/100ps
module io_board_model (
    input  wire logic [7:0] oe_n_i,  // Low while the port drives the pin
    input  wire logic [7:0] drv_i,   // Level the port drives
    input  wire logic [7:0] ext_i,   // Level the board drives
    output logic      [7:0] pin_o    // Resolved pin level
);
    always_comb begin
        pin_o = (drv_i & ~oe_n_i) | (ext_i & oe_n_i);
    end
endmodule // io_board_model

// >>> tb/dual_bank_io_port_tb_top.sv
/*
 Self-checking bench of the two-bank I/O port: register access over
 Avalon-MM, pin drive, edge flags and the edge interrupt.
 Assumes the one-wait read and zero-wait write of the slave.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    error_cnt++; $display("Error at %0t: got %h expected %h", \
    $time, (got), (exp)); end end
module dual_bank_io_port_tb_top;
    logic        mclk_i, rst_i, read_i, write_i, irq_o, waitrequest_o;
    logic [9:0]  address_i;
    logic [31:0] writedata_i, readdata_o;
    logic [3:0]  byteenable_i, be;
    logic [7:0]  ext [2];
    wire  [7:0]  pins_o [2];
    wire  [7:0]  oe_n [2];
    wire  [7:0]  pin [2];
    logic [7:0]  dir [2], pol [2], dreg [2], old [2], nx [2], d, wv, ef;
    logic [1:0]  act, mask, st;
    integer      seed = 32'h54c02b5e;
    int          error_cnt = 0, checks = 0;
    localparam logic [7:0] RIDX [11] = '{8'h30, 8'he0, 8'he1, 8'he2,
        8'he3, 8'he4, 8'he5, 8'he6, 8'he7, 8'h40, 8'h50};
    localparam logic [7:0] RVAL [11] = '{8'h03, 8'hff, 8'h00, 8'h00,
        8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    dual_bank_io_port dual_bank_io_port_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .bank_three_pins_i(pin[0]),
        .bank_three_pins_o(pins_o[0]), .bank_three_oe_n_o(oe_n[0]),
        .bank_four_pins_i(pin[1]), .bank_four_pins_o(pins_o[1]),
        .bank_four_oe_n_o(oe_n[1]), .irq_o(irq_o));
    for (genvar g = 0; g < 2; g++) begin : g_board
        io_board_model io_board_model_inst (.oe_n_i(oe_n[g]),
            .drv_i(pins_o[g]), .ext_i(ext[g]), .pin_o(pin[g]));
    end

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    function automatic logic [7:0] exp_val(int b);
        return (dreg[b] & ~dir[b]) | ((ext[b] ^ pol[b]) & dir[b]);
    endfunction
    function automatic logic [7:0] exp_flg(int b);
        return act[b] ? ((old[b] ^ nx[b]) & dir[b]) : 8'h00;
    endfunction

    task automatic wrap_up;
        $display("Checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd);
        address_i <= {idx, 2'b00};
        write_i <= wr;
        read_i <= ~wr;
        writedata_i <= {24'h0, wd};
        byteenable_i <= be;
        do begin
            @(posedge mclk_i);
        end while (waitrequest_o !== 1'b0);
        rd = readdata_o[7:0];
        write_i <= 1'b0;
        read_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic check_reset;
        for (int i = 0; i < 11; i++) begin
            bus(0, RIDX[i], 8'h00, d);
            `CHK(d, RVAL[i])
        end
        `CHK(oe_n[0] & oe_n[1], 8'hff)
        dreg = '{8'h00, 8'h00};
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        wrap_up();
    end

    initial begin
        rst_i = 1'b1; read_i = 1'b0; write_i = 1'b0; address_i = '0;
        writedata_i = '0; byteenable_i = 4'hf; be = 4'hf;
        ext = '{8'h00, 8'h00};
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        check_reset();
        for (int it = 0; it < 30; it++) begin
            act = (it < 2) ? 2'h3 : $random(seed);
            mask = $random(seed);
            bus(1, 8'h30, {6'h0, act}, d);
            bus(1, 8'h41, {6'h0, mask}, d);
            for (int b = 0; b < 2; b++) begin
                dir[b] = (it == 0) ? 8'h00 : $random(seed);
                pol[b] = $random(seed);
                wv = $random(seed);
                bus(1, 8'he0 + 4 * b, dir[b], d);
                bus(1, 8'he2 + 4 * b, pol[b], d);
                bus(1, 8'he1 + 4 * b, wv, d);
                dreg[b] = (dreg[b] & dir[b]) | (wv & ~dir[b]);
            end
            repeat (6) @(posedge mclk_i);
            for (int b = 0; b < 2; b++) bus(0, 8'he3 + 4 * b, 8'h00, d);
            bus(1, 8'h40, 8'h03, d);
            for (int b = 0; b < 2; b++) begin
                old[b] = ext[b];
                nx[b] = (it == 1) ? ~ext[b] : $random(seed);
                ext[b] <= nx[b];
            end
            repeat (6) @(posedge mclk_i);
            for (int b = 0; b < 2; b++) begin
                ef = exp_flg(b);
                st[b] = (ef != 8'h00);
                `CHK(oe_n[b], act[b] ? dir[b] : 8'hff)
                `CHK(pins_o[b] & ~dir[b], (dreg[b] ^ pol[b]) & ~dir[b])
                bus(0, 8'he0 + 4 * b, 8'h00, d);
                `CHK(d, dir[b])
                bus(0, 8'he1 + 4 * b, 8'h00, d);
                `CHK(d, exp_val(b))
                bus(1, 8'he3 + 4 * b, 8'h00, d);
                bus(0, 8'he3 + 4 * b, 8'h00, d);
                `CHK(d, ef)
                bus(0, 8'he3 + 4 * b, 8'h00, d);
                `CHK(d, 8'h00)
            end
            bus(0, 8'h40, 8'h00, d);
            `CHK(d, {6'h0, st})
            `CHK(irq_o, |(st & mask))
            bus(1, 8'h40, 8'h03, d);
            @(posedge mclk_i);
            `CHK(irq_o, 1'b0)
        end
        be = 4'h0;
        bus(1, 8'he2, ~pol[0], d);
        be = 4'hf;
        bus(0, 8'he2, 8'h00, d);
        `CHK(d, pol[0])
        bus(1, 8'h50, 8'h5a, d);
        bus(0, 8'h50, 8'h00, d);
        `CHK(d, 8'h00)
        ext <= '{8'h00, 8'h00};
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        check_reset();
        wrap_up();
    end
endmodule // dual_bank_io_port_tb_top
